//--- pkg/psi_pkg.sv
// Shared constants and types for the sensor word register port.
`default_nettype none
package psi_pkg;

  // ----------------------------------------------------------------
  // Bus addressing and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h60;
  localparam logic       BIT_WRITE  = 1'b0;
  localparam logic       BIT_READ   = 1'b1;
  localparam int         NUM_SET    = 7;
  localparam logic [7:0] CMD_FLAG   = 8'hF9;
  localparam logic [7:0] CMD_DATA   = 8'hF8;
  localparam logic [7:0] CMD_IDENT  = 8'hFA;
  localparam logic [7:0] CMD_ACDATA = 8'hFB;
  // Writable setting words, listed from index 6 down to index 0.
  localparam logic [NUM_SET-1:0][7:0] SET_CODE = {
    8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h00};
  localparam logic [NUM_SET-1:0][15:0] SET_RESET = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001};
  // Arbitrary value, reported by the identity word.
  localparam logic [15:0] IDENT_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYC =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [NUM_SET-1:0][15:0] psi_settings_t;

endpackage : psi_pkg
`default_nettype wire

//--- pkg/psi_i2c_if.sv
// Two-wire open-drain link between the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
interface psi_i2c_if;
  logic sclOe;
  logic sclOut;
  logic sdaHostOe;
  logic sdaHostOut;
  logic sdaDevOe;
  logic sdaDevOut;
  logic scl;
  logic sda;

  // A driver that is enabled with a low output pulls low; the pull-up wins otherwise.
  assign scl = !(sclOe && !sclOut);
  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

  modport device (input scl, input sda, output sdaDevOe, output sdaDevOut);
  modport host (input scl, input sda, output sclOe, output sclOut,
                output sdaHostOe, output sdaHostOut);
endinterface : psi_i2c_if
`default_nettype wire

//--- src/psi_i2c_device.sv
// Device end: two-wire target holding the command-code word registers.
//
// Overview of operation
// RULE1 - Answer only at seven-bit address 0x60.
// RULE2 - Write: address, command, low, high, stop.
// RULE3 - Read: command, restart, low acked, high nacked.
// RULE4 - Acknowledge address, command and written data bytes.
// RULE5 - Reading interrupt flag word clears pending interrupt.
// RULE6 - Host uses only word write and read.
// RULE7 - All settings reached only through command codes.
// RULE8 - Decode eight-bit command code to register word.
// RULE9 - Flag word shows which condition raised interrupt.
// RULE10 - Foreign address: stay released, no acknowledge.
`timescale 1ns/100ps
`default_nettype none
module psi_i2c_device (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Link
  psi_i2c_if.device                  bus,
  // Sensor side
  input  wire logic [15:0]           proximityMeasure,
  input  wire logic [15:0]           acData,
  input  wire logic [7:0]            intEventIn,
  output var  logic                  intOut,
  output var  psi_pkg::psi_settings_t settingsOut
);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX   = 3'b001,
    D_ACK  = 3'b010,
    D_TX   = 3'b011,
    D_MACK = 3'b100
  } psi_dev_state_t;

  typedef struct packed {
    logic                   sclS1;
    logic                   sclS2;
    logic                   sclPrev;
    logic                   sdaS1;
    logic                   sdaS2;
    logic                   sdaPrev;
    psi_dev_state_t         state;
    logic [3:0]             bitCnt;
    logic [7:0]             shreg;
    logic [1:0]             byteNum;
    logic                   rdMode;
    logic                   hostAck;
    logic [7:0]             cmd;
    logic [7:0]             wrLow;
    logic [7:0]             txHi;
    psi_pkg::psi_settings_t settings;
    logic [7:0]             flags;
    logic                   intPend;
    logic                   sdaOe;
    logic                   sdaOut;
  } psi_dev_reg_t;

  psi_dev_reg_t st_ff;
  psi_dev_reg_t nxt_st;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Returns {hit, index} of the setting word that a code selects.
  function automatic logic [3:0] setIndex(input logic [7:0] code);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < psi_pkg::NUM_SET; i++) begin
      if (code == psi_pkg::SET_CODE[i]) begin
        res = {1'b1, 3'(i)};                                  // [RULE8]
      end
    end
    return res;
  endfunction : setIndex

  logic [3:0]  rdIdx;
  logic [15:0] rdWord;

  always_comb begin
    rdIdx = setIndex(st_ff.cmd);
    if (rdIdx[3]) begin
      rdWord = st_ff.settings[rdIdx[2:0]];                    // [RULE7]
    end else if (st_ff.cmd == psi_pkg::CMD_DATA) begin
      rdWord = proximityMeasure;
    end else if (st_ff.cmd == psi_pkg::CMD_FLAG) begin
      rdWord = {st_ff.flags, 8'h00};                          // [RULE9]
    end else if (st_ff.cmd == psi_pkg::CMD_IDENT) begin
      rdWord = psi_pkg::IDENT_WORD;
    end else if (st_ff.cmd == psi_pkg::CMD_ACDATA) begin
      rdWord = acData;
    end else begin
      rdWord = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       clearFlags;
  logic [3:0] wrIdx;

  always_comb begin
    nxt_st     = st_ff;
    clearFlags = 1'b0;
    wrIdx      = setIndex(st_ff.cmd);
    // Pins pass two flip-flops; the edge finders compare the second with a third, one cycle older copy.
    nxt_st.sclS1   = bus.scl;
    nxt_st.sclS2   = st_ff.sclS1;
    nxt_st.sclPrev = st_ff.sclS2;
    nxt_st.sdaS1   = bus.sda;
    nxt_st.sdaS2   = st_ff.sdaS1;
    nxt_st.sdaPrev = st_ff.sdaS2;
    sclRise   = st_ff.sclS2 && !st_ff.sclPrev;
    sclFall   = !st_ff.sclS2 && st_ff.sclPrev;
    startCond = st_ff.sclS2 && st_ff.sclPrev && st_ff.sdaPrev && !st_ff.sdaS2;
    stopCond  = st_ff.sclS2 && st_ff.sclPrev && !st_ff.sdaPrev && st_ff.sdaS2;

    if (startCond) begin
      nxt_st.state   = D_RX;
      nxt_st.bitCnt  = 4'h0;
      nxt_st.byteNum = 2'h0;
      nxt_st.sdaOe   = 1'b0;
    end else if (stopCond) begin
      nxt_st.state = D_IDLE;
      nxt_st.sdaOe = 1'b0;
    end else begin
      case (st_ff.state)
        D_RX: begin
          if (sclRise && st_ff.bitCnt != 4'h8) begin
            nxt_st.shreg  = {st_ff.shreg[6:0], st_ff.sdaS2};
            nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
          end else if (sclFall && st_ff.bitCnt == 4'h8) begin
            nxt_st.bitCnt = 4'h0;
            if (st_ff.byteNum == 2'h0 && st_ff.shreg[7:1] != psi_pkg::DEV_ADDR) begin
              nxt_st.state = D_IDLE;                          // [RULE10]
            end else begin
              nxt_st.state = D_ACK;
              nxt_st.sdaOe = 1'b1;                            // [RULE4] [RULE1]
              case (st_ff.byteNum)
                2'h0: nxt_st.rdMode = st_ff.shreg[0];
                2'h1: nxt_st.cmd = st_ff.shreg;               // [RULE2]
                2'h2: nxt_st.wrLow = st_ff.shreg;
                default: begin
                  if (wrIdx[3]) begin
                    nxt_st.settings[wrIdx[2:0]] = {st_ff.shreg, st_ff.wrLow}; // [RULE7]
                  end
                end
              endcase
            end
          end
        end
        D_ACK: begin
          if (sclFall) begin
            nxt_st.sdaOe  = 1'b0;
            nxt_st.bitCnt = 4'h0;
            if (st_ff.rdMode == psi_pkg::BIT_READ) begin
              nxt_st.state = D_TX;                            // [RULE3]
              nxt_st.shreg = rdWord[7:0];
              nxt_st.txHi  = rdWord[15:8];
              nxt_st.sdaOe = !rdWord[7];
              clearFlags   = (st_ff.cmd == psi_pkg::CMD_FLAG); // [RULE5]
            end else begin
              nxt_st.state = D_RX;
              if (st_ff.byteNum != 2'h3) begin
                nxt_st.byteNum = st_ff.byteNum + 2'h1;
              end
            end
          end
        end
        D_TX: begin
          if (sclFall) begin
            if (st_ff.bitCnt == 4'h7) begin
              nxt_st.state = D_MACK;
              nxt_st.sdaOe = 1'b0;
            end else begin
              nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
              nxt_st.sdaOe  = !st_ff.shreg[6];
              nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (sclRise) begin
            nxt_st.hostAck = !st_ff.sdaS2;
          end else if (sclFall) begin
            if (st_ff.hostAck) begin
              nxt_st.state  = D_TX;                           // [RULE3]
              nxt_st.shreg  = st_ff.txHi;
              nxt_st.sdaOe  = !st_ff.txHi[7];
              nxt_st.bitCnt = 4'h0;
            end else begin
              nxt_st.state = D_IDLE;
            end
          end
        end
        default: nxt_st.state = D_IDLE;
      endcase
    end

    // An event in the same cycle as the clearing read sets its flag again.
    nxt_st.flags   = (clearFlags ? 8'h00 : st_ff.flags) | intEventIn; // [RULE9] [RULE5]
    nxt_st.intPend = |nxt_st.flags;
    nxt_st.sdaOut  = 1'b0;

    if (rst) begin
      nxt_st          = '0;
      nxt_st.sclS1    = 1'b1;
      nxt_st.sclS2    = 1'b1;
      nxt_st.sclPrev  = 1'b1;
      nxt_st.sdaS1    = 1'b1;
      nxt_st.sdaS2    = 1'b1;
      nxt_st.sdaPrev  = 1'b1;
      nxt_st.state    = D_IDLE;
      nxt_st.settings = psi_pkg::SET_RESET;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign bus.sdaDevOe  = st_ff.sdaOe;
  assign bus.sdaDevOut = st_ff.sdaOut;
  assign intOut        = st_ff.intPend;
  assign settingsOut   = st_ff.settings;

endmodule : psi_i2c_device
`default_nettype wire

//--- src/psi_i2c_host.sv
// Host end: two-wire controller issuing word writes and word reads.
`timescale 1ns/100ps
`default_nettype none
module psi_i2c_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Link
  psi_i2c_if.host          bus,
  // Request
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [7:0]  reqCmd,
  input  wire logic [15:0] reqData,
  output var  logic        reqReady,
  // Answer
  output var  logic        doneValid,
  output var  logic [15:0] rdData,
  output var  logic        nackErr
);

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BYTE  = 2'b10,
    H_STOP  = 2'b11
  } psi_host_state_t;

  typedef struct packed {
    psi_host_state_t state;
    logic [5:0]      qCnt;
    logic [1:0]      quarter;
    logic [2:0]      step;
    logic [3:0]      bitCnt;
    logic [7:0]      shreg;
    logic            rdByte;
    logic            isWrite;
    logic [7:0]      cmd;
    logic [15:0]     data;
    logic [15:0]     rdWord;
    logic            nack;
    logic            sdaS1;
    logic            sdaS2;
    logic            sclLow;
    logic            sdaLow;
    logic            ready;
    logic            done;
    logic            err;
  } psi_host_reg_t;

  localparam logic [5:0] Q_LAST = 6'(psi_pkg::SCL_QUARTER_CYC - 1);

  psi_host_reg_t st_ff;
  psi_host_reg_t nxt_st;

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  logic [2:0] nStep;
  logic [1:0] act;
  logic [7:0] txByte;
  logic       rdAct;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.done  = 1'b0;
    nxt_st.sdaS1 = bus.sda;
    nxt_st.sdaS2 = st_ff.sdaS1;
    nStep  = st_ff.step + 3'h1;
    act    = H_BYTE;
    rdAct  = 1'b0;
    txByte = 8'hFF;
    // Only the word sequences exist here.                     [RULE6]
    if (st_ff.isWrite) begin
      case (nStep)                                            // [RULE2]
        3'h1: txByte = {psi_pkg::DEV_ADDR, psi_pkg::BIT_WRITE}; // [RULE1]
        3'h2: txByte = st_ff.cmd;
        3'h3: txByte = st_ff.data[7:0];
        3'h4: txByte = st_ff.data[15:8];
        default: act = H_STOP;
      endcase
    end else begin
      case (nStep)                                            // [RULE3]
        3'h1: txByte = {psi_pkg::DEV_ADDR, psi_pkg::BIT_WRITE};
        3'h2: txByte = st_ff.cmd;
        3'h3: act = H_START;
        3'h4: txByte = {psi_pkg::DEV_ADDR, psi_pkg::BIT_READ};
        3'h5: rdAct = 1'b1;
        3'h6: rdAct = 1'b1;
        default: act = H_STOP;
      endcase
    end

    if (st_ff.state == H_IDLE) begin
      nxt_st.sclLow = 1'b0;
      nxt_st.sdaLow = 1'b0;
      if (reqValid && st_ff.ready) begin
        nxt_st.ready   = 1'b0;
        nxt_st.err     = 1'b0;
        nxt_st.isWrite = reqWrite;
        nxt_st.cmd     = reqCmd;
        nxt_st.data    = reqData;
        nxt_st.state   = H_START;
        nxt_st.step    = 3'h0;
        nxt_st.qCnt    = 6'h00;
        nxt_st.quarter = 2'h0;
      end
    end else if (st_ff.qCnt != Q_LAST) begin
      nxt_st.qCnt = st_ff.qCnt + 6'h01;
    end else begin
      nxt_st.qCnt    = 6'h00;
      nxt_st.quarter = st_ff.quarter + 2'h1;
      case (st_ff.quarter)
        2'h0: nxt_st.sclLow = 1'b0;
        2'h1: begin
          if (st_ff.state == H_START) begin
            nxt_st.sdaLow = 1'b1;
          end else if (st_ff.state == H_STOP) begin
            nxt_st.sdaLow = 1'b0;
          end else if (st_ff.bitCnt == 4'h8) begin
            nxt_st.nack = st_ff.sdaS2;
          end else if (st_ff.rdByte) begin
            nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sdaS2};
          end
        end
        2'h2: nxt_st.sclLow = (st_ff.state != H_STOP);
        default: begin
          if (st_ff.state == H_STOP) begin
            nxt_st.state = H_IDLE;
            nxt_st.ready = 1'b1;
            nxt_st.done  = 1'b1;
            nxt_st.sclLow = 1'b0;
          end else if (st_ff.state == H_BYTE && st_ff.bitCnt != 4'h8) begin
            nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
            if (st_ff.bitCnt == 4'h7) begin
              // Host acks the low byte and refuses the high byte.
              nxt_st.sdaLow = st_ff.rdByte && (st_ff.step == 3'h5); // [RULE3]
            end else if (!st_ff.rdByte) begin
              nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
              nxt_st.sdaLow = !st_ff.shreg[6];
            end
          end else begin
            if (st_ff.state == H_BYTE && st_ff.step == 3'h5) begin
              nxt_st.rdWord[7:0] = st_ff.shreg;
            end else if (st_ff.state == H_BYTE && st_ff.step == 3'h6) begin
              nxt_st.rdWord[15:8] = st_ff.shreg;
            end
            nxt_st.step = nStep;
            if (st_ff.state == H_BYTE && !st_ff.rdByte && st_ff.nack) begin
              nxt_st.err    = 1'b1;
              nxt_st.state  = H_STOP;
              nxt_st.sdaLow = 1'b1;
            end else begin
              nxt_st.state  = psi_host_state_t'(act);
              nxt_st.bitCnt = 4'h0;
              nxt_st.rdByte = rdAct;
              nxt_st.shreg  = rdAct ? 8'h00 : txByte;
              nxt_st.sdaLow = (act == H_STOP) || (act == H_BYTE && !rdAct && !txByte[7]);
            end
          end
        end
      endcase
    end

    if (rst) begin
      nxt_st       = '0;
      nxt_st.state = H_IDLE;
      nxt_st.sdaS1 = 1'b1;
      nxt_st.sdaS2 = 1'b1;
      nxt_st.ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign bus.sclOe      = st_ff.sclLow;
  assign bus.sclOut     = 1'b0;
  assign bus.sdaHostOe  = st_ff.sdaLow;
  assign bus.sdaHostOut = 1'b0;
  assign reqReady       = st_ff.ready;
  assign doneValid      = st_ff.done;
  assign rdData         = st_ff.rdWord;
  assign nackErr        = st_ff.err;

endmodule : psi_i2c_host
`default_nettype wire

//--- dv/psi_i2c_sva.sv
// Wire-level protocol checker for the two-wire link between both ends.
`timescale 1ns/100ps
`default_nettype none
module psi_i2c_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic sclOe,
  input wire logic sclOut,
  input wire logic sdaHostOe,
  input wire logic sdaHostOut,
  input wire logic sdaDevOe,
  input wire logic sdaDevOut,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // Frame tracking: bit index since the last start, address and direction
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sclQ;
    logic       sdaQ;
    logic [5:0] bitCnt;
    logic       rw;
    logic [6:0] addr;
  } psi_mon_t;
  psi_mon_t mon_ff;
  psi_mon_t nxt_mon;
  logic     rise;
  logic     start;
  assign rise  = scl && !mon_ff.sclQ;
  assign start = scl && mon_ff.sclQ && mon_ff.sdaQ && !sda;
  always_comb begin
    nxt_mon      = mon_ff;
    nxt_mon.sclQ = scl;
    nxt_mon.sdaQ = sda;
    if (start) begin
      nxt_mon.bitCnt = 6'h00;
    end else if (rise && mon_ff.bitCnt != 6'h3F) begin
      nxt_mon.bitCnt = mon_ff.bitCnt + 6'h01;
    end
    if (rise && mon_ff.bitCnt < 6'h07) begin
      nxt_mon.addr = {mon_ff.addr[5:0], sda};
    end
    if (rise && mon_ff.bitCnt == 6'h07) begin
      nxt_mon.rw = sda;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      mon_ff <= '{sclQ: 1'b1, sdaQ: 1'b1, default: '0};
    end else begin
      mon_ff <= nxt_mon;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_addr_match;
    rise && mon_ff.bitCnt == 6'h07 |-> mon_ff.addr == psi_pkg::DEV_ADDR;
  endproperty
  property p_addr_ack;
    rise && mon_ff.bitCnt == 6'h08 |-> !sda;
  endproperty
  property p_write_ack;
    rise && !mon_ff.rw && mon_ff.bitCnt inside {6'h11, 6'h1A, 6'h23} |-> !sda;
  endproperty
  property p_read_ack;
    rise && mon_ff.rw && mon_ff.bitCnt == 6'h11 |-> !sda;
  endproperty
  property p_read_nack;
    rise && mon_ff.rw && mon_ff.bitCnt == 6'h1A |-> sda;
  endproperty
  property p_frame_len;
    rise |-> !((!mon_ff.rw && mon_ff.bitCnt > 6'h24) || (mon_ff.rw && mon_ff.bitCnt > 6'h1B));
  endproperty
  property p_dev_stable_high;
    scl && mon_ff.sclQ |-> $stable(sdaDevOe) && !(sdaDevOe && sdaDevOut);
  endproperty
  property p_dev_hold;
    $rose(sdaDevOe) |-> !scl ##0 sdaDevOe [*8];
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("address on the link differs from the device address");
  a_addr_ack: assert property (p_addr_ack)
    else $error("address byte not acknowledged");
  a_write_ack: assert property (p_write_ack)
    else $error("written byte not acknowledged");
  a_read_ack: assert property (p_read_ack)
    else $error("low read byte not acknowledged by host");
  a_read_nack: assert property (p_read_nack)
    else $error("high read byte not refused by host");
  a_frame_len: assert property (p_frame_len)
    else $error("frame longer than a word transfer");
  a_dev_stable_high: assert property (p_dev_stable_high)
    else $error("device changed its drive while the clock was high");
  a_dev_hold: assert property (p_dev_hold)
    else $error("device drive began with clock high or was too short");
  c_write: cover property (rise && !mon_ff.rw && mon_ff.bitCnt == 6'h23);
  c_read: cover property (rise && mon_ff.rw && mon_ff.bitCnt == 6'h1A);
  c_restart: cover property (start && mon_ff.bitCnt == 6'h13);
endmodule : psi_i2c_sva
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                   clk;
  logic                   rst;
  logic                   reqValid;
  logic                   reqWrite;
  logic [7:0]             reqCmd;
  logic [15:0]            reqData;
  logic                   reqReady;
  logic                   doneValid;
  logic [15:0]            rdData;
  logic                   nackErr;
  logic [15:0]            proximityMeasure;
  logic [15:0]            acData;
  logic [7:0]             intEventIn;
  logic                   intOut;
  psi_pkg::psi_settings_t settingsOut;
  psi_pkg::psi_settings_t expSet;
  logic                   devDrove2;
  int                     fails;
  int                     numChecks;

  psi_i2c_if bus ();
  psi_i2c_if bus2 ();
  psi_i2c_host psi_i2c_host_i (.clk(clk), .rst(rst), .bus(bus), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqCmd(reqCmd), .reqData(reqData), .reqReady(reqReady),
    .doneValid(doneValid), .rdData(rdData), .nackErr(nackErr));
  psi_i2c_device psi_i2c_device_i (.clk(clk), .rst(rst), .bus(bus),
    .proximityMeasure(proximityMeasure), .acData(acData), .intEventIn(intEventIn),
    .intOut(intOut), .settingsOut(settingsOut));
  // Second device on a link whose host side is driven directly by the bench.
  psi_i2c_device psi_i2c_device_i2 (.clk(clk), .rst(rst), .bus(bus2),
    .proximityMeasure(proximityMeasure), .acData(acData), .intEventIn(intEventIn),
    .intOut(), .settingsOut());
  psi_i2c_sva psi_i2c_sva_i (.clk(clk), .rst(rst), .sclOe(bus.sclOe), .sclOut(bus.sclOut),
    .sdaHostOe(bus.sdaHostOe), .sdaHostOut(bus.sdaHostOut), .sdaDevOe(bus.sdaDevOe),
    .sdaDevOut(bus.sdaDevOut), .scl(bus.scl), .sda(bus.sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (bus2.sdaDevOe === 1'b1) devDrove2 <= 1'b1;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
    int n;
    n = 0;
    reqValid = 1'b1;
    reqWrite = wr;
    reqCmd = cmd;
    reqData = d;
    step(1);
    reqValid = 1'b0;
    check({15'h0000, reqReady}, 16'h0000);
    while (doneValid !== 1'b1 && n < 10000) begin
      step(1);
      n++;
    end
    check({15'h0000, doneValid}, 16'h0001);
    check({15'h0000, reqReady}, 16'h0001);
    check({15'h0000, nackErr}, 16'h0000);
  endtask : access

  task automatic checkSet;
    for (int j = 0; j < psi_pkg::NUM_SET; j++) check(settingsOut[j], expSet[j]);
  endtask : checkSet

  task automatic readWord(input logic [7:0] cmd, input logic [15:0] exp);
    access(1'b0, cmd, 16'h0000);
    check(rdData, exp);
  endtask : readWord

  // Bench-made link clock of eight system clocks; the ninth slot is left released.
  task automatic rawFrame(input logic [6:0] a);
    logic [8:0] bits;
    bits = {a, 1'b0, 1'b1};
    devDrove2 = 1'b0;
    bus2.sdaHostOe = 1'b1;
    step(4);
    for (int i = 8; i >= 0; i--) begin
      bus2.sclOe = 1'b1;
      step(2);
      bus2.sdaHostOe = !bits[i];
      step(2);
      bus2.sclOe = 1'b0;
      step(4);
    end
    bus2.sclOe = 1'b1;
    step(2);
    bus2.sdaHostOe = 1'b1;
    step(2);
    bus2.sclOe = 1'b0;
    step(2);
    bus2.sdaHostOe = 1'b0;
    step(8);
  endtask : rawFrame

  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqCmd = 8'h00;
    reqData = 16'h0000;
    proximityMeasure = 16'h0ABC;
    acData = 16'h8421;
    intEventIn = 8'h00;
    devDrove2 = 1'b0;
    fails = 0;
    numChecks = 0;
    bus2.sclOe = 1'b0;
    bus2.sclOut = 1'b0;
    bus2.sdaHostOe = 1'b0;
    bus2.sdaHostOut = 1'b0;
    expSet = psi_pkg::SET_RESET;
    step(4);
    rst = 1'b0;
    checkSet();
    check({15'h0000, intOut}, 16'h0000);
    for (int i = 0; i < psi_pkg::NUM_SET; i++) begin
      access(1'b1, psi_pkg::SET_CODE[i], 16'hC35A + 16'(i));
      expSet[i] = 16'hC35A + 16'(i);
      checkSet();
    end
    readWord(psi_pkg::SET_CODE[3], expSet[3]);
    access(1'b1, psi_pkg::CMD_DATA, 16'h1234);
    checkSet();
    intEventIn = 8'h05;
    step(1);
    intEventIn = 8'h00;
    step(3);
    check({15'h0000, intOut}, 16'h0001);
    readWord(psi_pkg::CMD_DATA, 16'h0ABC);
    check({15'h0000, intOut}, 16'h0001);
    readWord(psi_pkg::CMD_ACDATA, 16'h8421);
    readWord(psi_pkg::CMD_IDENT, psi_pkg::IDENT_WORD);
    readWord(psi_pkg::CMD_FLAG, 16'h0500);
    step(3);
    check({15'h0000, intOut}, 16'h0000);
    rawFrame(psi_pkg::DEV_ADDR);
    check({15'h0000, devDrove2}, 16'h0001);
    rawFrame(7'h61);
    check({15'h0000, devDrove2}, 16'h0000);
    rawFrame(7'h20);
    check({15'h0000, devDrove2}, 16'h0000);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
